//--- logic/atb_pkg.sv
// Package: register map, field layout and fuse order of the trim bank
package atb_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_OFF_A   = 10'h34C;
  localparam logic [9:0] IDX_OFF_B   = 10'h34E;
  localparam logic [9:0] IDX_GA0_DUAL = 10'h350;
  localparam logic [9:0] IDX_GA1_DUAL = 10'h351;
  localparam logic [9:0] IDX_GB0_DUAL = 10'h352;
  localparam logic [9:0] IDX_GB1_DUAL = 10'h353;
  localparam logic [9:0] IDX_GA0_SNGL = 10'h354;
  localparam logic [9:0] IDX_GA1_SNGL = 10'h355;
  localparam logic [9:0] IDX_GB0_SNGL = 10'h356;
  localparam logic [9:0] IDX_GB1_SNGL = 10'h357;
  // ==========================================================
  // Storage slots, also the fuse word order
  localparam int          NUM_SLOT = 10;
  localparam logic [3:0] SLOT_OFF_A   = 4'h0;
  localparam logic [3:0] SLOT_OFF_B   = 4'h1;
  localparam logic [3:0] SLOT_GA0_DUAL = 4'h2;
  localparam logic [3:0] SLOT_GA1_DUAL = 4'h3;
  localparam logic [3:0] SLOT_GB0_DUAL = 4'h4;
  localparam logic [3:0] SLOT_GB1_DUAL = 4'h5;
  localparam logic [3:0] SLOT_GA0_SNGL = 4'h6;
  localparam logic [3:0] SLOT_GA1_SNGL = 4'h7;
  localparam logic [3:0] SLOT_GB0_SNGL = 4'h8;
  localparam logic [3:0] SLOT_GB1_SNGL = 4'h9;
  localparam logic [3:0] SLOT_LAST     = 4'h9;
  // ==========================================================
  // Field widths and reset values
  localparam int          REG_W     = 16;
  localparam int          OFFSET_W  = 12;
  localparam int          GAIN_W    = 5;
  localparam int          GAIN_REG_W = 8;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // ==========================================================
  // Fuse loader states
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_REQ  = 3'b010,
    FL_DONE = 3'b100
  } atb_fuse_st_t;
endpackage

//--- logic/atb_fuse_loader.sv
// Fuse loader: walks every trim slot once after reset
`timescale 1ns/1ns
module atb_fuse_loader
  import atb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  output logic             fuseReq,
  output logic [3:0]       fuseIdx,
  input  wire logic        fuseAck,
  input  wire logic [15:0] fuseData,
  output logic             loadValid,
  output logic [3:0]       loadIdx,
  output logic [15:0]      loadData,
  output logic             busy
);
  typedef struct packed {
    atb_fuse_st_t st;
    logic [3:0]   idx;
    logic         vld;
    logic [3:0]   lIdx;
    logic [15:0]  lData;
  } atb_fl_t;
  atb_fl_t q;
  atb_fl_t d;

  // ==========================================================
  // Next state: one request per slot, data handed on as a pulse
  always_comb
  begin
    d = q;
    d.vld = 1'b0;
    unique case (q.st)
      FL_IDLE: d.st = FL_REQ;
      FL_REQ:
      begin
        if (fuseAck)
        begin
          d.vld   = 1'b1;
          d.lIdx  = q.idx;
          d.lData = fuseData;
          if (q.idx == SLOT_LAST)
            d.st = FL_DONE;
          else
            d.idx = q.idx + 4'h1;
        end
      end
      FL_DONE: d.st = FL_DONE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= '{st: FL_IDLE, idx: 4'h0, vld: 1'b0, lIdx: 4'h0, lData: REG_RESET};
    else
      q <= d;
  end

  assign fuseReq   = (q.st == FL_REQ);
  assign fuseIdx   = q.idx;
  assign loadValid = q.vld;
  assign loadIdx   = q.lIdx;
  assign loadData  = q.lData;
  assign busy      = (q.st != FL_DONE) || q.vld; // Bus held off until last word lands
endmodule // atb_fuse_loader

//--- logic/atb_trim_select.sv
// Trim select: routes stored trims to the converter cores
`timescale 1ns/1ns
module atb_trim_select
  import atb_pkg::*;
(
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  input  wire logic [NUM_SLOT-1:0][REG_W-1:0]  trim,
  input  wire logic                            singleChannel,
  input  wire logic                            calEnable,
  input  wire logic                            sampleInputB,
  output logic [OFFSET_W-1:0]                  coreBOffset,
  output logic [GAIN_W-1:0]                    coreAGain0,
  output logic [GAIN_W-1:0]                    coreAGain1,
  output logic [GAIN_W-1:0]                    coreBGain0,
  output logic [GAIN_W-1:0]                    coreBGain1
);
  typedef struct packed {
    logic [OFFSET_W-1:0] off;
    logic [GAIN_W-1:0]   a0;
    logic [GAIN_W-1:0]   a1;
    logic [GAIN_W-1:0]   b0;
    logic [GAIN_W-1:0]   b1;
  } atb_sel_t;
  atb_sel_t q;
  atb_sel_t d;

  // Low gain field of a slot
  function automatic logic [GAIN_W-1:0] gainOf(input logic [3:0] s);
    gainOf = trim[s][GAIN_W-1:0];
  endfunction

  // ==========================================================
  // Offset by sampled input, one pair for both modes; gain set by mode
  always_comb
  begin
    d = q;
    if (!calEnable)
      d.off = '0;
    else if (sampleInputB)
      d.off = trim[SLOT_OFF_B][OFFSET_W-1:0];
    else
      d.off = trim[SLOT_OFF_A][OFFSET_W-1:0];
    if (singleChannel)
    begin
      d.a0 = gainOf(SLOT_GA0_SNGL);
      d.a1 = gainOf(SLOT_GA1_SNGL);
      d.b0 = gainOf(SLOT_GB0_SNGL);
      d.b1 = gainOf(SLOT_GB1_SNGL);
    end
    else
    begin
      d.a0 = gainOf(SLOT_GA0_DUAL);
      d.a1 = gainOf(SLOT_GA1_DUAL);
      d.b0 = gainOf(SLOT_GB0_DUAL);
      d.b1 = gainOf(SLOT_GB1_DUAL);
    end
  end

  // Output register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign coreBOffset = q.off;
  assign coreAGain0  = q.a0;
  assign coreAGain1  = q.a1;
  assign coreBGain0  = q.b0;
  assign coreBGain1  = q.b1;
endmodule // atb_trim_select

//--- logic/atb_trim_bank.sv
// Trim bank top: Avalon-MM slave, trim storage, fuse load and routing
`timescale 1ns/1ns
module atb_trim_bank
  import atb_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  output logic                    fuseReq,
  output logic [3:0]              fuseIdx,
  input  wire logic               fuseAck,
  input  wire logic [15:0]        fuseData,
  input  wire logic               singleChannel,
  input  wire logic               calEnable,
  input  wire logic               sampleInputB,
  output logic [OFFSET_W-1:0]     coreBOffset,
  output logic [GAIN_W-1:0]       coreAGain0,
  output logic [GAIN_W-1:0]       coreAGain1,
  output logic [GAIN_W-1:0]       coreBGain0,
  output logic [GAIN_W-1:0]       coreBGain1,
  output logic                    trimLoaded
);
  // ==========================================================
  // Elaboration check
  if (ADDR_W < 12)
  begin : gAddrCheck
    $error("ADDR_W too narrow for the trim bank map");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_SLOT-1:0][REG_W-1:0] trim;
    logic                           rdValid;
    logic [31:0]                    rdData;
  } atb_state_t;
  atb_state_t q;
  atb_state_t d;

  logic        loadValid;
  logic [3:0]  loadIdx;
  logic [15:0] loadData;
  logic        busy;
  logic [9:0]  regIdx;
  logic        hit;
  logic [3:0]  slot;

  // ==========================================================
  // Address decode: word index to storage slot
  function automatic logic [4:0] decodeSlot(input logic [9:0] idx);
    unique case (idx)
      IDX_OFF_A:    decodeSlot = {1'b1, SLOT_OFF_A};
      IDX_OFF_B:    decodeSlot = {1'b1, SLOT_OFF_B};
      IDX_GA0_DUAL: decodeSlot = {1'b1, SLOT_GA0_DUAL};
      IDX_GA1_DUAL: decodeSlot = {1'b1, SLOT_GA1_DUAL};
      IDX_GB0_DUAL: decodeSlot = {1'b1, SLOT_GB0_DUAL};
      IDX_GB1_DUAL: decodeSlot = {1'b1, SLOT_GB1_DUAL};
      IDX_GA0_SNGL: decodeSlot = {1'b1, SLOT_GA0_SNGL};
      IDX_GA1_SNGL: decodeSlot = {1'b1, SLOT_GA1_SNGL};
      IDX_GB0_SNGL: decodeSlot = {1'b1, SLOT_GB0_SNGL};
      IDX_GB1_SNGL: decodeSlot = {1'b1, SLOT_GB1_SNGL};
      default:      decodeSlot = 5'h00;
    endcase
  endfunction

  // Offset registers are 16 bits wide, gain registers 8
  function automatic logic isWide(input logic [3:0] s);
    isWide = (s == SLOT_OFF_A) || (s == SLOT_OFF_B);
  endfunction

  assign regIdx = avs_address[11:2];
  assign {hit, slot} = decodeSlot(regIdx);

  // ==========================================================
  // Fuse loader
  atb_fuse_loader uLoader (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .fuseReq   (fuseReq),
    .fuseIdx   (fuseIdx),
    .fuseAck   (fuseAck),
    .fuseData  (fuseData),
    .loadValid (loadValid),
    .loadIdx   (loadIdx),
    .loadData  (loadData),
    .busy      (busy)
  );

  // ==========================================================
  // Next state: fuse words, bus writes, registered read data
  always_comb
  begin
    d = q;
    d.rdValid = 1'b0;
    if (loadValid)
    begin
      // Fuse default lands in its slot
      if (isWide(loadIdx))
        d.trim[loadIdx] = loadData;
      else
        d.trim[loadIdx] = {8'h00, loadData[GAIN_REG_W-1:0]};
    end
    else if (!busy && avs_write && hit)
    begin
      // Byte lanes 0 and 1; narrow registers take lane 0 only
      if (avs_byteenable[0])
        d.trim[slot][7:0] = avs_writedata[7:0];
      if (avs_byteenable[1] && isWide(slot))
        d.trim[slot][15:8] = avs_writedata[15:8];
    end
    if (!busy && avs_read && !q.rdValid)
    begin
      d.rdValid = 1'b1;
      d.rdData  = hit ? {16'h0000, q.trim[slot]} : RD_UNMAPPED;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  // ==========================================================
  // Bus answers: writes in one cycle, reads in two
  assign avs_waitrequest = busy || (avs_read && !q.rdValid);
  assign avs_readdata    = q.rdData;
  assign trimLoaded      = !busy;

  // ==========================================================
  // Routing to the cores
  atb_trim_select uSelect (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .trim          (q.trim),
    .singleChannel (singleChannel),
    .calEnable     (calEnable),
    .sampleInputB  (sampleInputB),
    .coreBOffset   (coreBOffset),
    .coreAGain0    (coreAGain0),
    .coreAGain1    (coreAGain1),
    .coreBGain0    (coreBGain0),
    .coreBGain1    (coreBGain1)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence rdIssue;
    avs_read && avs_waitrequest && !busy;
  endsequence
  sequence rdAnswer;
    avs_read && !avs_waitrequest;
  endsequence

  read_answer_a: assert property (rdIssue ##1 avs_read |-> rdAnswer)
    else $error("read not answered on next cycle");

  offset_in_a_a: assert property (calEnable && !sampleInputB
    |=> coreBOffset == $past(q.trim[SLOT_OFF_A][OFFSET_W-1:0]))
    else $error("core B offset not from input A register");

  offset_in_b_a: assert property (calEnable && sampleInputB
    |=> coreBOffset == $past(q.trim[SLOT_OFF_B][OFFSET_W-1:0]))
    else $error("core B offset not from input B register");

  offset_shared_a: assert property (calEnable && singleChannel && !sampleInputB
    |=> coreBOffset == $past(q.trim[SLOT_OFF_A][OFFSET_W-1:0]))
    else $error("single mode used another offset copy");

  fuse_default_a: assert property (loadValid
    |=> q.trim[$past(loadIdx)][GAIN_REG_W-1:0] == $past(loadData[GAIN_REG_W-1:0]))
    else $error("fuse word not loaded");

  gain_dual_a_a: assert property (!singleChannel
    |=> coreAGain0 == $past(q.trim[SLOT_GA0_DUAL][GAIN_W-1:0])
        && coreAGain1 == $past(q.trim[SLOT_GA1_DUAL][GAIN_W-1:0]))
    else $error("dual core A gain wrong");

  gain_dual_b_a: assert property (!singleChannel
    |=> coreBGain0 == $past(q.trim[SLOT_GB0_DUAL][GAIN_W-1:0])
        && coreBGain1 == $past(q.trim[SLOT_GB1_DUAL][GAIN_W-1:0]))
    else $error("dual core B gain wrong");

  gain_single_a_a: assert property (singleChannel
    |=> coreAGain0 == $past(q.trim[SLOT_GA0_SNGL][GAIN_W-1:0])
        && coreAGain1 == $past(q.trim[SLOT_GA1_SNGL][GAIN_W-1:0]))
    else $error("single core A gain wrong");

  gain_single_b_a: assert property (singleChannel
    |=> coreBGain0 == $past(q.trim[SLOT_GB0_SNGL][GAIN_W-1:0])
        && coreBGain1 == $past(q.trim[SLOT_GB1_SNGL][GAIN_W-1:0]))
    else $error("single core B gain wrong");

  mode_follow_a: assert property ($rose(singleChannel)
    |=> coreBGain1 == $past(q.trim[SLOT_GB1_SNGL][GAIN_W-1:0]))
    else $error("gain set did not follow mode");

  cal_off_a: assert property (!calEnable ##1 1'b1 |-> coreBOffset == '0)
    else $error("offset applied without calibration");

  // Second offset register also serves single channel mode
  offset_single_b_a: assert property (calEnable && singleChannel && sampleInputB
    |=> coreBOffset == $past(q.trim[SLOT_OFF_B][OFFSET_W-1:0]))
    else $error("single mode used another input B offset");

  // Leaving single mode brings the dual set back on the next cycle
  mode_back_a: assert property ($fell(singleChannel)
    |=> coreAGain0 == $past(q.trim[SLOT_GA0_DUAL][GAIN_W-1:0]))
    else $error("gain set did not return to dual");

  // ==========================================================
  // Bus write checks
  sequence wrLowLane;
    avs_write && !avs_waitrequest && hit && avs_byteenable[0];
  endsequence
  sequence wrHighLane;
    avs_write && !avs_waitrequest && hit && avs_byteenable[1] && isWide(slot);
  endsequence
  sequence wrNarrow;
    avs_write && !avs_waitrequest && hit && !isWide(slot);
  endsequence

  // Accepted writes land in the addressed slot
  wr_low_lane_a: assert property (wrLowLane
    |=> q.trim[$past(slot)][7:0] == $past(avs_writedata[7:0]))
    else $error("low byte lane write lost");

  wr_high_lane_a: assert property (wrHighLane
    |=> q.trim[$past(slot)][15:8] == $past(avs_writedata[15:8]))
    else $error("high byte lane write lost");

  // Gain registers never take the upper lane
  gain_lane_a: assert property (wrNarrow
    |=> q.trim[$past(slot)][REG_W-1:GAIN_REG_W] == '0)
    else $error("gain register took upper lane");

  // Unmapped or stalled writes leave the storage untouched
  unmapped_wr_a: assert property (avs_write && !hit && !busy
    |=> q.trim == $past(q.trim))
    else $error("unmapped write changed storage");

  busy_wr_a: assert property (avs_write && busy && !loadValid
    |=> q.trim == $past(q.trim))
    else $error("write taken during fuse load");

  // Writes answer with no wait state once loaded
  wr_no_wait_a: assert property (avs_write && !avs_read && !busy
    |-> !avs_waitrequest)
    else $error("write stalled after load");

  // Fuse load holds the whole bus off
  busy_hold_a: assert property (busy |-> avs_waitrequest)
    else $error("bus open during fuse load");

  // ==========================================================
  // Bus read checks
  rd_data_a: assert property (rdIssue and hit
    |=> avs_readdata == {16'h0000, $past(q.trim[slot])})
    else $error("read data not from addressed register");

  rd_unmapped_a: assert property (rdIssue and !hit
    |=> avs_readdata == RD_UNMAPPED)
    else $error("unmapped read not zero");

  // Read data stands until the next read is answered
  rd_stands_a: assert property (!(avs_read && avs_waitrequest && !busy)
    |=> avs_readdata == $past(avs_readdata))
    else $error("read data changed without a read");

  // ==========================================================
  // Fuse loader checks
  fuse_first_a: assert property ($rose(fuseReq) |-> fuseIdx == SLOT_OFF_A)
    else $error("fuse walk did not start at first slot");

  fuse_step_a: assert property (fuseReq && fuseAck && fuseIdx != SLOT_LAST
    |=> fuseIdx == $past(fuseIdx) + 4'h1)
    else $error("fuse index did not advance");

  fuse_wait_a: assert property (fuseReq && !fuseAck
    |=> fuseReq && fuseIdx == $past(fuseIdx))
    else $error("fuse request not held");

  fuse_ignored_a: assert property (!fuseReq |=> !loadValid)
    else $error("fuse word taken without request");

  loaded_done_a: assert property (trimLoaded |-> !fuseReq)
    else $error("fuse request after load");

  loaded_stays_a: assert property (trimLoaded |=> trimLoaded)
    else $error("trim loaded flag dropped");

  fuse_wide_a: assert property (loadValid && isWide(loadIdx)
    |=> q.trim[$past(loadIdx)] == $past(loadData))
    else $error("offset fuse word not loaded whole");
endmodule // atb_trim_bank

//--- sim/tb.sv
// Testbench for the trim bank: fuse defaults, register access and trim routing
`timescale 1ns/1ns
module tb;
  import atb_pkg::*;
  // ==========================================================
  // Signals
  logic                core_clk;
  logic                rst_n;
  logic [11:0]         avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                fuseReq;
  logic [3:0]          fuseIdx;
  logic                fuseAck;
  logic [15:0]         fuseData;
  logic                singleChannel;
  logic                calEnable;
  logic                sampleInputB;
  logic [OFFSET_W-1:0] coreBOffset;
  logic [GAIN_W-1:0]   coreAGain0;
  logic [GAIN_W-1:0]   coreAGain1;
  logic [GAIN_W-1:0]   coreBGain0;
  logic [GAIN_W-1:0]   coreBGain1;
  logic                trimLoaded;
  int                  numErrors;
  int                  nCompared;
  logic [31:0]         rdq;

  atb_trim_bank uut (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fuseReq(fuseReq),
    .fuseIdx(fuseIdx), .fuseAck(fuseAck), .fuseData(fuseData), .singleChannel(singleChannel),
    .calEnable(calEnable), .sampleInputB(sampleInputB), .coreBOffset(coreBOffset),
    .coreAGain0(coreAGain0), .coreAGain1(coreAGain1), .coreBGain0(coreBGain0),
    .coreBGain1(coreBGain1), .trimLoaded(trimLoaded)
  );

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    #300000;
    numErrors++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================
  // Helpers
  function automatic logic [11:0] slotAddr(input int s);
    logic [9:0] idx;
    idx = (s == 0) ? IDX_OFF_A : (s == 1) ? IDX_OFF_B : IDX_GA0_DUAL + 10'(s - 2);
    return {idx, 2'b00};
  endfunction

  // Distinct fuse word per slot; gain field of a gain slot equals the slot number
  function automatic logic [15:0] fuseWord(input int s);
    return 16'hC3A0 | 16'(s);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Fuse storage: acks every other cycle while a word is requested
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fuseAck  <= 1'b0;
      fuseData <= 16'h0000;
    end
    else if (fuseReq === 1'b1 && fuseAck === 1'b0)
    begin
      fuseAck  <= 1'b1;
      fuseData <= fuseWord(int'(fuseIdx));
    end
    else
      fuseAck <= 1'b0;
  end

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    n = 0;
    // Sample waitrequest at each rising edge; take read data at the answering edge
    do
    begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    if (n >= 100)
    begin
      numErrors++;
      $display("BAD %0t bus transfer never answered", $time);
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Walks all eight mode combinations and checks every trim output
  task automatic sweep(input logic [11:0] offA, input logic [11:0] offB,
                       input logic [4:0] gDual, input logic [4:0] gSngl);
    logic [4:0]  g;
    logic [11:0] eo;
    for (int m = 0; m < 8; m++)
    begin
      @(posedge core_clk);
      singleChannel <= m[2];
      calEnable     <= m[1];
      sampleInputB  <= m[0];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      eo = m[1] ? (m[0] ? offB : offA) : 12'h000;
      g  = m[2] ? gSngl : gDual;
      chk(32'(coreBOffset), 32'(eo), "core B offset");
      chk(32'(coreAGain0), 32'(g), "core A bank 0 gain");
      chk(32'(coreAGain1), 32'(g + 5'h01), "core A bank 1 gain");
      chk(32'(coreBGain0), 32'(g + 5'h02), "core B bank 0 gain");
      chk(32'(coreBGain1), 32'(g + 5'h03), "core B bank 1 gain");
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_fuse_load();
    int n;
    n = 0;
    while (trimLoaded !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(trimLoaded), 32'h0000_0001, "fuse load finished");
    chk(32'(fuseReq), 32'h0000_0000, "fuse request dropped");
    sweep(12'h3A0, 12'h3A1, 5'h02, 5'h06);
    for (int s = 0; s < NUM_SLOT; s++)
    begin
      bus(1'b0, slotAddr(s), 32'h0000_0000, 4'hF, rdq);
      chk(rdq, (s < 2) ? 32'(fuseWord(s)) : 32'(fuseWord(s) & 16'h00FF), "fuse readback");
    end
    bus(1'b0, 12'hD34, 32'h0000_0000, 4'hF, rdq);
    chk(rdq, 32'h0000_0000, "unmapped read");
  endtask

  task automatic test_offsets();
    bus(1'b1, slotAddr(0), 32'hFFFF_5ABC, 4'hF, rdq);
    bus(1'b1, slotAddr(1), 32'h0000_12EF, 4'h1, rdq);
    bus(1'b1, 12'hD34, 32'h0000_0FFF, 4'hF, rdq);
    bus(1'b0, slotAddr(0), 32'h0000_0000, 4'hF, rdq);
    chk(rdq, 32'h0000_5ABC, "offset A readback");
    bus(1'b0, slotAddr(1), 32'h0000_0000, 4'hF, rdq);
    chk(rdq, 32'h0000_C3EF, "offset B lane write");
    sweep(12'hABC, 12'h3EF, 5'h02, 5'h06);
  endtask

  task automatic test_gains();
    for (int s = 2; s < NUM_SLOT; s++)
      bus(1'b1, slotAddr(s), 32'hFFFF_FFE0 | 32'(s + 8), 4'hF, rdq);
    for (int s = 2; s < NUM_SLOT; s++)
    begin
      bus(1'b0, slotAddr(s), 32'h0000_0000, 4'hF, rdq);
      chk(rdq, 32'h0000_00E0 | 32'(s + 8), "gain readback");
    end
    sweep(12'hABC, 12'h3EF, 5'h0A, 5'h0E);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n          = 1'b0;
    avs_address    = 12'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
    singleChannel  = 1'b0;
    calEnable      = 1'b0;
    sampleInputB   = 1'b0;
    numErrors      = 0;
    nCompared      = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    test_fuse_load();
    test_offsets();
    test_gains();
    finish_test();
  end
endmodule // tb
